// file: hdl/rsci_bank.v
// Remap status, root table base and context invalidation register bank.
// Assumes a single AHB-Lite master on hclk; translation and invalidation
// engines outside are modelled by fixed-length internal operations.
//
// Overview of operation
// - Translation status reads 1 only while remapping is active.
// - Load-root-pointer command clears the root-pointer-loaded status.
// - Root-pointer-loaded sets in the same cycle the base is latched into the working pointer.
// - Load-fault-log command clears the fault-log-loaded status.
// - Fault-log-loaded sets once the fault log pointer is adopted.
// - Fault-logging status shows 1 enabled, 0 disabled, if supported.
// - Flush command sets flush-in-progress when flushing is required.
// - Flush-in-progress clears when the internal flush completes.
// - Root base holds bits 63:12, low 12 reserved, reads last write.
// - Root base bits at and above host address width are unimplemented.
// - Top-byte write with invalidate bit set starts context invalidation.
// - Completion clears invalidate bit and updates actual granularity together.
// - When flushing is required, flush before clearing the invalidate bit.
// - Requested granularity: 00 reserved, 01 global, 10 domain, 11 device.
// - Device may invalidate coarser than requested, reporting what it did.
// - Actual granularity reports 01 global, 11 device only when asked, or 00 for a reserved request.
// - Write-only function mask selects masked function bits; reads as zero.
// - Domain field holds supported width only; upper bits unimplemented.
// - Translation status changes only when an enable command completes.
// - Fault-logging status follows completion of the logging enable command.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/10ps
`include "rsci_defs.vh"

module rsci_bank (
    // Clock and reset
    input wire hclk,
    input wire hresetn,
    // AHB-Lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    // Status towards the remapping datapath
    output reg translation_active,
    output reg [63:0] root_pointer_r,
    output reg [1:0] function_mask_r,
    output reg [15:0] source_id_field_r
);

    // ****************************************
    // Operation engine states
    // ****************************************
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_FLUSH = 2'b01;
    localparam [1:0] ST_INVAL = 2'b10;
    localparam integer OP_CYC = `RSCI_OP_CYCLES;
    localparam [3:0] OP_LEN = OP_CYC[3:0];
    localparam [63:0] ROOT_MASK =
        ((64'h0000_0000_0000_0001 << `RSCI_HOST_ADDR_WIDTH) - 64'h0000_0000_0000_0001)
        & 64'hffff_ffff_ffff_f000;
    localparam [15:0] DOMAIN_MASK = (16'h0001 << `RSCI_DOMAIN_WIDTH) - 16'h0001;

    // Granularity actually used; domain requests are done globally
    function [1:0] act_gran;
        input [1:0] req;
        begin
            case (req)
                `RSCI_GRAN_DEVICE: act_gran = `RSCI_GRAN_DEVICE;
                `RSCI_GRAN_RESERVED: act_gran = `RSCI_GRAN_RESERVED;
                default: act_gran = `RSCI_GRAN_GLOBAL;
            endcase
        end
    endfunction

    // ****************************************
    // Bus address phase capture
    // ****************************************
    reg wr_pend_r;
    reg rd_pend_r;
    reg rd_wait_r;
    reg [7:0] addr_r;
    wire take = hsel & hready & htrans[1];

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            wr_pend_r <= take & hwrite;
            // Read data phase spans the wait state
            if (hready)
                rd_pend_r <= take & ~hwrite;
            rd_wait_r <= rd_pend_r & ~rd_wait_r;
            if (take)
                addr_r <= haddr;
        end
    end

    // One wait state on reads so registered hrdata stands in the data phase;
    // it also lets a write just before the read land first. Always OKAY.
    assign hreadyout = ~(rd_pend_r & ~rd_wait_r);
    assign hresp = 1'b0;

    wire wr_gcmd = wr_pend_r && addr_r == `RSCI_OFF_GLOBAL_CMD;
    wire wr_root_lo = wr_pend_r && addr_r == `RSCI_OFF_ROOT_BASE_LO;
    wire wr_root_hi = wr_pend_r && addr_r == `RSCI_OFF_ROOT_BASE_HI;
    wire wr_ctx_lo = wr_pend_r && addr_r == `RSCI_OFF_CTX_CMD_LO;
    wire wr_ctx_hi = wr_pend_r && addr_r == `RSCI_OFF_CTX_CMD_HI;
    wire wr_ctrl = wr_pend_r && addr_r == `RSCI_OFF_CTRL;

    // ****************************************
    // Registers
    // ****************************************
    reg [63:0] root_base_r;
    reg [31:0] ctrl_r;
    reg root_loaded_r;
    reg fault_log_loaded_r;
    reg fault_logging_r;
    reg flush_busy_r;
    reg invalidate_r;
    reg [1:0] req_gran_r;
    reg [1:0] act_gran_r;
    reg [15:0] domain_r;
    reg [1:0] state_r;
    reg [1:0] state_nxt;
    reg [3:0] cnt_r;
    reg [3:0] cnt_nxt;
    reg pend_root_r;
    reg pend_log_r;

    wire flush_cap = ctrl_r[`RSCI_CTRL_FLUSH_CAP];
    wire log_cap = ctrl_r[`RSCI_CTRL_LOGGING_CAP];
    wire g_te = hwdata[`RSCI_BIT_TRANSLATION];
    wire g_root = hwdata[`RSCI_BIT_ROOT];
    wire g_log = hwdata[`RSCI_BIT_FAULT_LOG];
    wire g_logging = hwdata[`RSCI_BIT_FAULT_LOGGING];
    wire g_flush = hwdata[`RSCI_BIT_FLUSH];
    wire ctx_start = wr_ctx_hi & hwdata[`RSCI_HI_INVALIDATE] & ~invalidate_r;
    wire op_done = (state_r != ST_IDLE) && cnt_r == 4'h1;

    // ****************************************
    // Flush and invalidation engine
    // ****************************************
    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            ST_IDLE: begin
                if (ctx_start) begin
                    // Flush first when required, then invalidate
                    state_nxt = flush_cap ? ST_FLUSH : ST_INVAL;
                    cnt_nxt = OP_LEN;
                end else if (wr_gcmd && g_flush && flush_cap) begin
                    state_nxt = ST_FLUSH;
                    cnt_nxt = OP_LEN;
                end
            end
            ST_FLUSH: begin
                if (cnt_r == 4'h1) begin
                    state_nxt = invalidate_r ? ST_INVAL : ST_IDLE;
                    cnt_nxt = invalidate_r ? OP_LEN : 4'h0;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            ST_INVAL: begin
                if (cnt_r == 4'h1) begin
                    state_nxt = ST_IDLE;
                    cnt_nxt = 4'h0;
                end else begin
                    cnt_nxt = cnt_r - 4'h1;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
                cnt_nxt = 4'h0;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // ****************************************
    // Global status and pointer loading
    // ****************************************
    // Pointer loads complete one cycle after the command
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            translation_active <= 1'b0;
            root_pointer_r <= 64'h0000_0000_0000_0000;
            root_loaded_r <= 1'b0;
            fault_log_loaded_r <= 1'b0;
            fault_logging_r <= 1'b0;
            flush_busy_r <= 1'b0;
            pend_root_r <= 1'b0;
            pend_log_r <= 1'b0;
        end else begin
            pend_root_r <= wr_gcmd & g_root;
            pend_log_r <= wr_gcmd & g_log & log_cap;
            if (wr_gcmd)
                translation_active <= g_te;
            if (wr_gcmd && log_cap)
                fault_logging_r <= g_logging;
            if (pend_root_r) begin
                root_pointer_r <= root_base_r;
                root_loaded_r <= 1'b1;
            end else if (wr_gcmd && g_root) begin
                root_loaded_r <= 1'b0;
            end
            if (pend_log_r)
                fault_log_loaded_r <= 1'b1;
            else if (wr_gcmd && g_log && log_cap)
                fault_log_loaded_r <= 1'b0;
            if (wr_gcmd && g_flush && flush_cap)
                flush_busy_r <= 1'b1;
            else if (state_r == ST_FLUSH && cnt_r == 4'h1)
                flush_busy_r <= 1'b0;
        end
    end

    // ****************************************
    // Root base and context command registers
    // ****************************************
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            root_base_r <= 64'h0000_0000_0000_0000;
            ctrl_r <= `RSCI_CTRL_RESET;
            invalidate_r <= 1'b0;
            req_gran_r <= 2'h0;
            act_gran_r <= 2'h0;
            domain_r <= 16'h0000;
            function_mask_r <= 2'h0;
            source_id_field_r <= 16'h0000;
        end else begin
            // Unimplemented and reserved bits never stored
            if (wr_root_lo)
                root_base_r[31:0] <= hwdata & ROOT_MASK[31:0];
            if (wr_root_hi)
                root_base_r[63:32] <= hwdata & ROOT_MASK[63:32];
            if (wr_ctrl)
                ctrl_r <= {30'h0000_0000, hwdata[1:0]};
            // Writes while busy are dropped so the request stays intact
            if (wr_ctx_lo && !invalidate_r) begin
                domain_r <= hwdata[15:0] & DOMAIN_MASK;
                source_id_field_r <= hwdata[31:16];
            end
            if (ctx_start) begin
                invalidate_r <= 1'b1;
                req_gran_r <= hwdata[`RSCI_HI_REQ_MSB:`RSCI_HI_REQ_LSB];
                function_mask_r <= hwdata[1:0];
            end else if (wr_ctx_hi && !invalidate_r) begin
                req_gran_r <= hwdata[`RSCI_HI_REQ_MSB:`RSCI_HI_REQ_LSB];
                function_mask_r <= hwdata[1:0];
            end
            if (state_r == ST_INVAL && op_done) begin
                invalidate_r <= 1'b0;
                act_gran_r <= act_gran(req_gran_r);
            end
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    reg [31:0] rd_val;
    always @* begin
        case (addr_r)
            `RSCI_OFF_GLOBAL_STATUS:
                rd_val = {translation_active, root_loaded_r, fault_log_loaded_r,
                          fault_logging_r, flush_busy_r, 27'h000_0000};
            `RSCI_OFF_ROOT_BASE_LO: rd_val = root_base_r[31:0];
            `RSCI_OFF_ROOT_BASE_HI: rd_val = root_base_r[63:32];
            // Write-only fields read as zero
            `RSCI_OFF_CTX_CMD_LO: rd_val = {16'h0000, domain_r};
            `RSCI_OFF_CTX_CMD_HI:
                rd_val = {invalidate_r, req_gran_r, act_gran_r, 27'h000_0000};
            `RSCI_OFF_CTRL: rd_val = ctrl_r;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (rd_pend_r && !rd_wait_r)
            hrdata <= rd_val;
    end

endmodule

// file: hdl/rsci_defs.vh
// Register offsets, field positions and timing counts of the remap status,
// root table base and context invalidation register bank.
// Assumes inclusion by the bank module only; definitions only.
`ifndef RSCI_DEFS_VH
`define RSCI_DEFS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RSCI_OFF_GLOBAL_STATUS 8'h1c
`define RSCI_OFF_ROOT_BASE_LO 8'h20
`define RSCI_OFF_ROOT_BASE_HI 8'h24
`define RSCI_OFF_CTX_CMD_LO 8'h28
`define RSCI_OFF_CTX_CMD_HI 8'h2c
`define RSCI_OFF_GLOBAL_CMD 8'h18
`define RSCI_OFF_CTRL 8'h30

// ****************************************
// Field positions
// ****************************************
`define RSCI_BIT_TRANSLATION 31
`define RSCI_BIT_ROOT 30
`define RSCI_BIT_FAULT_LOG 29
`define RSCI_BIT_FAULT_LOGGING 28
`define RSCI_BIT_FLUSH 27
// Positions inside the upper word of the context command register
`define RSCI_HI_INVALIDATE 31
`define RSCI_HI_REQ_MSB 30
`define RSCI_HI_REQ_LSB 29
`define RSCI_HI_ACT_MSB 28
`define RSCI_HI_ACT_LSB 27
// Control register fields
`define RSCI_CTRL_FLUSH_CAP 0
`define RSCI_CTRL_LOGGING_CAP 1

// ****************************************
// Granularity encodings
// ****************************************
`define RSCI_GRAN_RESERVED 2'h0
`define RSCI_GRAN_GLOBAL 2'h1
`define RSCI_GRAN_DOMAIN 2'h2
`define RSCI_GRAN_DEVICE 2'h3

// ****************************************
// Widths and reset values
// ****************************************
`define RSCI_HOST_ADDR_WIDTH 48
`define RSCI_DOMAIN_WIDTH 8
`define RSCI_CTRL_RESET 32'h0000_0003

// ****************************************
// Timing
// ****************************************
`define RSCI_CLK_NS 100
`define RSCI_OP_TIME_NS 400
`define RSCI_OP_CYCLES ((`RSCI_OP_TIME_NS + `RSCI_CLK_NS - 1) / `RSCI_CLK_NS)

`endif

// file: tb/rsci_bank_checker.sv
// Concurrent checks on the register bank's ports.
// Assumes one AHB-Lite master on hclk; reads take one wait state.
`timescale 1ns/10ps
module rsci_bank_checker (
    // Bus
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire hreadyout,
    input wire hresp,
    input wire [31:0] hrdata,
    // Datapath
    input wire translation_active,
    input wire [63:0] root_pointer_r,
    input wire [1:0] function_mask_r,
    input wire [15:0] source_id_field_r
);
    // ************************
    // Data phase tracking
    // ************************
    reg dp_r;
    reg wr_r;
    reg [7:0] a_r;
    reg [35:0] base_r;
    wire wr = dp_r && wr_r;
    wire rd = dp_r && !wr_r;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_r <= 1'b0;
            wr_r <= 1'b0;
            a_r <= 8'h00;
            base_r <= 36'h0_0000_0000;
        end else begin
            dp_r <= hsel && hready && htrans[1];
            wr_r <= hwrite;
            a_r <= haddr;
            if (wr && a_r == 8'h20) base_r[19:0] <= hwdata[31:12];
            if (wr && a_r == 8'h24) base_r[35:20] <= hwdata[15:0];
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ************************
    // Assertions
    // ************************
    chk_trans_follow: assert property (wr && a_r == 8'h18 |=>
        translation_active == $past(hwdata[31])) else $error("translation status wrong");
    chk_trans_hold: assert property (!(wr && a_r == 8'h18) |=>
        $stable(translation_active)) else $error("translation status moved");
    chk_root_latch: assert property (wr && a_r == 8'h18 && hwdata[30] |=>
        ##[0:3] root_pointer_r[47:12] == base_r) else $error("root pointer not latched");
    chk_mask_take: assert property (wr && a_r == 8'h2c |=>
        function_mask_r == $past(hwdata[1:0])) else $error("function mask not taken");
    chk_sid_take: assert property (wr && a_r == 8'h28 |=>
        source_id_field_r == $past(hwdata[31:16])) else $error("source id not taken");
    chk_status_rsvd: assert property (rd && a_r == 8'h1c |=>
        hrdata[26:0] == 27'h000_0000) else $error("status reserved bits set");
    chk_root_low: assert property (rd && a_r == 8'h20 |=>
        hrdata[11:0] == 12'h000) else $error("root base low bits set");
    chk_root_top: assert property (rd && a_r == 8'h24 |=>
        hrdata[31:16] == 16'h0000) else $error("root base top bits set");
    chk_dom_width: assert property (rd && a_r == 8'h28 |=>
        hrdata[31:8] == 24'h00_0000) else $error("domain width exceeded");
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    cover property (wr && a_r == 8'h2c && hwdata[31]);
    cover property (wr && a_r == 8'h18 && hwdata[27]);
    cover property (rd && a_r == 8'h1c);
endmodule

// file: tb/remap_status_ctx_invalidate_tb.sv
// Self-checking bench for the register bank over AHB-Lite.
// Assumes hready may stay low in a data phase; read data stands in it.
`timescale 1ns/10ps
module remap_status_ctx_invalidate_tb;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg [7:0] haddr = 8'h00;
    reg [1:0] htrans = 2'h0;
    reg hwrite = 1'b0;
    reg [2:0] hsize = 3'h2;
    reg [31:0] hwdata = 32'h0000_0000;
    wire hready;
    wire hresp;
    wire [31:0] hrdata;
    wire translation_active;
    wire [63:0] root_ptr;
    wire [1:0] fmask;
    wire [15:0] source_id_field;
    integer mismatches = 0;
    integer n_tests = 0;
    integer cyc = 0;
    integer i;
    integer g;
    integer ts;
    integer ls;
    integer fl = 0;
    int act_q[$] = '{0, 1, 1, 3};
    logic [31:0] cmds [4] = '{32'h8000_0000, 32'h9000_0000, 32'h2000_0000, 32'h0000_0000};
    reg [31:0] rd;
    reg [31:0] lo;
    reg [31:0] hi;
    reg [1:0] act;
    always #50 hclk = ~hclk;
    rsci_bank DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .translation_active(translation_active), .root_pointer_r(root_ptr),
        .function_mask_r(fmask), .source_id_field_r(source_id_field));
    // ************************
    // Tasks
    // ************************
    task check(input [31:0] seen, input [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // hready and hrdata are looked at mid-cycle, where they are settled
    task bus(input w, input [7:0] a, input [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(negedge hclk);
        while (hready !== 1'b1) @(negedge hclk);
        @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(negedge hclk);
        while (hready !== 1'b1) @(negedge hclk);
        rd = hrdata;
        @(posedge hclk);
    endtask
    task wrap_up;
        $display("tests=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches = mismatches + 1;
            wrap_up;
        end
    end
    // ************************
    // Tests
    // ************************
    initial begin
        i = $urandom(67254);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(0, 8'h1c, 0);
        check(rd, 0);
        bus(0, 8'h40, 0);
        check(rd, 0);
        $display("reset test done");
        lo = $urandom;
        hi = $urandom;
        bus(1, 8'h20, lo);
        bus(1, 8'h24, hi);
        bus(0, 8'h20, 0);
        check(rd, lo & 32'hffff_f000);
        bus(0, 8'h24, 0);
        check(rd, hi & 32'h0000_ffff);
        bus(1, 8'h18, 32'h4000_0000);
        bus(0, 8'h1c, 0);
        check(rd, 32'h4000_0000);
        check(root_ptr[31:0], lo & 32'hffff_f000);
        check(root_ptr[63:32], hi & 32'h0000_ffff);
        $display("root test done");
        for (i = 0; i < 4; i = i + 1) begin
            bus(1, 8'h18, cmds[i]);
            ts = cmds[i][31];
            ls = cmds[i][28];
            fl = fl | cmds[i][29];
            bus(0, 8'h1c, 0);
            check(rd, (ts << 31) | (1 << 30) | (fl << 29) | (ls << 28));
            check(translation_active, ts);
        end
        bus(1, 8'h18, 32'h0800_0000);
        bus(0, 8'h1c, 0);
        check(rd[27], 1);
        repeat (6) @(posedge hclk);
        bus(0, 8'h1c, 0);
        check(rd, 32'h6000_0000);
        $display("command test done");
        for (g = 0; g < 4; g = g + 1) begin
            lo = $urandom;
            bus(1, 8'h28, lo);
            hi = 32'h8000_0000 | (g << 29) | ($urandom & 3);
            bus(1, 8'h2c, hi); // nothing else outstanding
            check(source_id_field, lo[31:16]);
            rd = 32'hffff_ffff;
            for (i = 0; i < 30 && rd[31] !== 1'b0; i = i + 1) bus(0, 8'h2c, 0);
            check(fmask, hi[1:0]);
            // Translation-cache flush belongs to another unit
            act = act_q[g][1:0];
            check(rd[31:27], {1'b0, hi[30:29], act});
            bus(0, 8'h28, 0);
            check(rd, lo & 32'h0000_00ff);
        end
        $display("invalidation test done");
        wrap_up;
    end
endmodule
bind rsci_bank rsci_bank_checker chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .translation_active(translation_active), .root_pointer_r(root_pointer_r),
    .function_mask_r(function_mask_r), .source_id_field_r(source_id_field_r));
